// *** core/pwmet_event_trigger.v ***
// Event-trigger selection with APB registers, event prescalers and outputs.
// Assumes time-base counter, compares and digital-compare events arrive
// synchronous to ref_clk, one sample per time-base clock.
//
// Decided for this implementation: the APB register port and the placing of the registers.
`default_nettype none
`include "pwmet_consts.vh"

module pwmet_event_trigger (
	// Clock and reset
	input  wire        ref_clk,
	input  wire        sys_rst,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output wire        pslverr,
	output reg  [31:0] prdata,
	// Time-base and compare values
	input  wire [15:0] timebase_count,
	input  wire [15:0] timebase_period,
	input  wire        timebase_count_up,
	input  wire [15:0] compare_value_a,
	input  wire [15:0] compare_value_b,
	// Digital-compare conversion events
	input  wire        dcmp_a_event1_conv,
	input  wire        dcmp_b_event1_conv,
	// Outputs
	output wire        conv_a_pulse,
	output wire        conv_b_pulse,
	output wire        module_irq
);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg  [15:0] event_trigger_select_r;
	reg  [1:0]  prd_b_r;                    // Conversion B period
	reg  [1:0]  prd_a_r;                    // Conversion A period
	reg  [1:0]  prd_irq_r;                  // Interrupt period
	reg  [15:0] tb_count_r;
	reg         tb_valid_r;
	reg  [15:0] rd_nxt;

	wire        wr_en;
	wire        rd_en;
	wire        hit_sel;
	wire        hit_ps;
	wire [15:0] prescale_view;
	wire [1:0]  cnt_a;
	wire [1:0]  cnt_b;
	wire [1:0]  cnt_irq;

	// Field views of the selection register
	wire        conv_b_pulse_enable;
	wire [2:0]  conv_b_source_select;
	wire        conv_a_pulse_enable;
	wire [2:0]  conv_a_source_select;
	wire        irq_enable;
	wire [2:0]  irq_source_select;
	assign conv_b_pulse_enable  = event_trigger_select_r[`PWMET_SEL_B_EN];
	assign conv_b_source_select = event_trigger_select_r[`PWMET_SEL_B_SRC];
	assign conv_a_pulse_enable  = event_trigger_select_r[`PWMET_SEL_A_EN];
	assign conv_a_source_select = event_trigger_select_r[`PWMET_SEL_A_SRC];
	assign irq_enable           = event_trigger_select_r[`PWMET_SEL_IRQ_EN];
	assign irq_source_select    = event_trigger_select_r[`PWMET_SEL_IRQ_SRC];

	// Period fields, B then A then interrupt
	wire [1:0]  conv_b_event_period;
	wire [1:0]  conv_a_event_period;
	wire [1:0]  irq_event_period;
	assign conv_b_event_period = prd_b_r;
	assign conv_a_event_period = prd_a_r;
	assign irq_event_period    = prd_irq_r;

	// ----------------------------------------
	// APB slave
	// ----------------------------------------

	// Phase strobes of a transfer
	wire        apb_setup;
	wire        apb_access;
	assign apb_setup  = psel && !penable;
	assign apb_access = psel && penable;

	// Zero-wait slave; pready never drops, every access ends at once
	assign pready = 1'b1;

	// Address decode; only the two word offsets are mapped
	assign hit_sel = (paddr == `PWMET_OFS_SELECT);
	assign hit_ps  = (paddr == `PWMET_OFS_PRESCALE);

	// Unmapped address errors in the access phase only
	assign pslverr = apb_access && !(hit_sel || hit_ps);

	// Write in the access phase, read capture in the setup phase
	assign wr_en = apb_access && pwrite;
	assign rd_en = apb_setup && !pwrite;

	// Per-register write strobes
	wire        wr_sel;
	wire        wr_ps;
	assign wr_sel = wr_en && hit_sel;
	assign wr_ps  = wr_en && hit_ps;

	// Write data split into the writable fields
	wire [15:0] sel_wdata;
	wire [1:0]  wdat_b_prd;
	wire [1:0]  wdat_a_prd;
	wire [1:0]  wdat_irq_prd;
	assign sel_wdata    = pwdata[15:0] & `PWMET_SEL_WMASK;
	assign wdat_b_prd   = pwdata[`PWMET_PS_B_PRD];
	assign wdat_a_prd   = pwdata[`PWMET_PS_A_PRD];
	assign wdat_irq_prd = pwdata[`PWMET_PS_IRQ_PRD];

	// Selection register; reserved bits never store a one
	always @(posedge ref_clk) begin
		if (sys_rst)
			event_trigger_select_r <= `PWMET_SEL_RESET;
		else if (wr_sel)
			event_trigger_select_r <= sel_wdata;
	end

	// Conversion B period field
	always @(posedge ref_clk) begin
		if (sys_rst)
			prd_b_r <= `PWMET_PRD_OFF;
		else if (wr_ps)
			prd_b_r <= wdat_b_prd;
	end

	// Conversion A period field
	always @(posedge ref_clk) begin
		if (sys_rst)
			prd_a_r <= `PWMET_PRD_OFF;
		else if (wr_ps)
			prd_a_r <= wdat_a_prd;
	end

	// Interrupt period field
	always @(posedge ref_clk) begin
		if (sys_rst)
			prd_irq_r <= `PWMET_PRD_OFF;
		else if (wr_ps)
			prd_irq_r <= wdat_irq_prd;
	end

	// Prescale view: counts read-only, periods read-write
	assign prescale_view = {cnt_b, conv_b_event_period, cnt_a, conv_a_event_period,
		`PWMET_PS_GAP, cnt_irq, irq_event_period};

	// Read mux; unmapped addresses read zero
	always @* begin
		rd_nxt = `PWMET_RD_ZERO;
		if (hit_sel)
			rd_nxt = event_trigger_select_r;
		else if (hit_ps)
			rd_nxt = prescale_view;
	end

	// Read data captured in setup phase, held until the next read
	always @(posedge ref_clk) begin
		if (sys_rst)
			prdata <= `PWMET_RDATA_RESET;
		else if (rd_en)
			prdata <= {`PWMET_RD_ZERO, rd_nxt};
	end

	// ----------------------------------------
	// Time-base event strobes
	// ----------------------------------------

	// Previous counter value for change detection
	always @(posedge ref_clk) begin
		if (sys_rst)
			tb_count_r <= `PWMET_CTR_ZERO;
		else
			tb_count_r <= timebase_count;
	end

	// First sample after reset counts as a change
	always @(posedge ref_clk) begin
		if (sys_rst)
			tb_valid_r <= 1'b0;
		else
			tb_valid_r <= 1'b1;
	end

	// Counter value entered this cycle: one strobe per occurrence
	wire fresh;
	assign fresh = !tb_valid_r || (timebase_count != tb_count_r);

	// Raw value matches
	wire eq_zero;
	wire eq_prd;
	wire eq_ca;
	wire eq_cb;
	assign eq_zero = (timebase_count == `PWMET_CTR_ZERO);
	assign eq_prd  = (timebase_count == timebase_period);
	assign eq_ca   = (timebase_count == compare_value_a);
	assign eq_cb   = (timebase_count == compare_value_b);

	// Count direction qualifiers
	wire dir_up;
	wire dir_dn;
	assign dir_up = timebase_count_up;
	assign dir_dn = !timebase_count_up;

	// Event strobes, one per counter value entered
	wire ev_zero;
	wire ev_prd;
	wire ev_cau;
	wire ev_cad;
	wire ev_cbu;
	wire ev_cbd;
	assign ev_zero = fresh && eq_zero;
	assign ev_prd  = fresh && eq_prd;
	assign ev_cau  = fresh && eq_ca && dir_up;
	assign ev_cad  = fresh && eq_ca && dir_dn;
	assign ev_cbu  = fresh && eq_cb && dir_up;
	assign ev_cbd  = fresh && eq_cb && dir_dn;

	// Interrupt selector has no digital-compare source
	wire irq_dcmp_none;
	assign irq_dcmp_none = `PWMET_NO_EVENT;

	// Picked event of each selector
	wire sel_a;
	wire sel_b;
	wire sel_irq;

	// ----------------------------------------
	// Source selectors
	// ----------------------------------------

	// Conversion A source
	pwmet_src_mux u_mux_a (
		.sel        (conv_a_source_select),
		.dcmp_ev    (dcmp_a_event1_conv),
		.ev_zero    (ev_zero),
		.ev_prd     (ev_prd),
		.ev_compare_value_a_up (ev_cau),
		.ev_compare_value_a_dn (ev_cad),
		.ev_compare_value_b_up (ev_cbu),
		.ev_compare_value_b_dn (ev_cbd),
		.ev_out     (sel_a)
	);

	// Conversion B source
	pwmet_src_mux u_mux_b (
		.sel        (conv_b_source_select),
		.dcmp_ev    (dcmp_b_event1_conv),
		.ev_zero    (ev_zero),
		.ev_prd     (ev_prd),
		.ev_compare_value_a_up (ev_cau),
		.ev_compare_value_a_dn (ev_cad),
		.ev_compare_value_b_up (ev_cbu),
		.ev_compare_value_b_dn (ev_cbd),
		.ev_out     (sel_b)
	);

	// Interrupt source; reserved code feeds no event
	pwmet_src_mux u_mux_irq (
		.sel        (irq_source_select),
		.dcmp_ev    (irq_dcmp_none),
		.ev_zero    (ev_zero),
		.ev_prd     (ev_prd),
		.ev_compare_value_a_up (ev_cau),
		.ev_compare_value_a_dn (ev_cad),
		.ev_compare_value_b_up (ev_cbu),
		.ev_compare_value_b_dn (ev_cbd),
		.ev_out     (sel_irq)
	);

	// ----------------------------------------
	// Prescalers
	// ----------------------------------------

	// Registered pulses from the prescalers
	wire pulse_a;
	wire pulse_b;
	wire pulse_irq;

	// Conversion A prescaler, gated by its enable
	pwmet_prescaler u_ps_a (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.enable  (conv_a_pulse_enable),
		.period  (conv_a_event_period),
		.ev_in   (sel_a),
		.count_r (cnt_a),
		.pulse_r (pulse_a)
	);

	// Conversion B prescaler, gated by its enable
	pwmet_prescaler u_ps_b (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.enable  (conv_b_pulse_enable),
		.period  (conv_b_event_period),
		.ev_in   (sel_b),
		.count_r (cnt_b),
		.pulse_r (pulse_b)
	);

	// Interrupt prescaler, gated by its enable
	pwmet_prescaler u_ps_irq (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.enable  (irq_enable),
		.period  (irq_event_period),
		.ev_in   (sel_irq),
		.count_r (cnt_irq),
		.pulse_r (pulse_irq)
	);

	// ----------------------------------------
	// Outputs
	// ----------------------------------------

	// One-cycle pulses straight from flip-flops
	assign conv_a_pulse = pulse_a;
	assign conv_b_pulse = pulse_b;
	assign module_irq   = pulse_irq;

endmodule
`default_nettype wire

// *** include/pwmet_consts.vh ***
// Constants for the PWM event-trigger selection block.
// Assumes inclusion by bare name from the core design files.
`ifndef PWMET_CONSTS_VH
`define PWMET_CONSTS_VH

// ----------------------------------------
// Register byte offsets on APB
// ----------------------------------------
`define PWMET_OFS_SELECT    12'h000
`define PWMET_OFS_PRESCALE  12'h004
`define PWMET_ADDR_W        12

// ----------------------------------------
// Selection register fields
// ----------------------------------------
`define PWMET_SEL_B_EN      15
`define PWMET_SEL_B_SRC     14:12
`define PWMET_SEL_A_EN      11
`define PWMET_SEL_A_SRC     10:8
`define PWMET_SEL_IRQ_EN    3
`define PWMET_SEL_IRQ_SRC   2:0
`define PWMET_SEL_WMASK     16'hff0f
`define PWMET_SEL_RESET     16'h0000

// ----------------------------------------
// Prescale register fields
// ----------------------------------------
`define PWMET_PS_B_CNT      15:14
`define PWMET_PS_B_PRD      13:12
`define PWMET_PS_A_CNT      11:10
`define PWMET_PS_A_PRD      9:8
`define PWMET_PS_IRQ_CNT    3:2
`define PWMET_PS_IRQ_PRD    1:0
`define PWMET_PS_RESET      16'h0000

// ----------------------------------------
// Source codes
// ----------------------------------------
`define PWMET_SRC_DCMP      3'h0
`define PWMET_SRC_ZERO      3'h1
`define PWMET_SRC_PRD       3'h2
`define PWMET_SRC_ZERO_PRD  3'h3
`define PWMET_SRC_COMPARE_VALUE_A_UP   3'h4
`define PWMET_SRC_COMPARE_VALUE_A_DN   3'h5
`define PWMET_SRC_COMPARE_VALUE_B_UP   3'h6
`define PWMET_SRC_COMPARE_VALUE_B_DN   3'h7

`define PWMET_CTR_ZERO      16'h0000
`define PWMET_PRD_OFF       2'h0
`define PWMET_CNT_ONE       2'h1
`define PWMET_CNT_CLEAR     2'h0

// ----------------------------------------
// Read data and fill values
// ----------------------------------------
`define PWMET_PS_GAP        4'h0
`define PWMET_RD_ZERO       16'h0000
`define PWMET_RDATA_RESET   32'h0000_0000
`define PWMET_NO_EVENT      1'b0

`endif

// *** core/pwmet_src_mux.v ***
// Source selector: picks the digital-compare event, one time-base event or zero-or-period by a 3-bit code.
// Assumes the event inputs are one-cycle strobes in the ref_clk domain.
`default_nettype none
`include "pwmet_consts.vh"

module pwmet_src_mux (
	// Selection
	input  wire [2:0] sel,
	input  wire       dcmp_ev,
	// Time-base strobes
	input  wire       ev_zero,
	input  wire       ev_prd,
	input  wire       ev_compare_value_a_up,
	input  wire       ev_compare_value_a_dn,
	input  wire       ev_compare_value_b_up,
	input  wire       ev_compare_value_b_dn,
	// Picked event
	output reg        ev_out
);

	// Code to event
	always @* begin
		case (sel)
			`PWMET_SRC_DCMP:     ev_out = dcmp_ev;
			`PWMET_SRC_ZERO:     ev_out = ev_zero;
			`PWMET_SRC_PRD:      ev_out = ev_prd;
			`PWMET_SRC_ZERO_PRD: ev_out = ev_zero | ev_prd;
			`PWMET_SRC_COMPARE_VALUE_A_UP:  ev_out = ev_compare_value_a_up;
			`PWMET_SRC_COMPARE_VALUE_A_DN:  ev_out = ev_compare_value_a_dn;
			`PWMET_SRC_COMPARE_VALUE_B_UP:  ev_out = ev_compare_value_b_up;
			`PWMET_SRC_COMPARE_VALUE_B_DN:  ev_out = ev_compare_value_b_dn;
			default:             ev_out = 1'b0;
		endcase
	end

endmodule
`default_nettype wire

// *** core/pwmet_prescaler.v ***
// Event prescaler: counts selected events, pulses on the programmed count.
// Assumes ev_in is a one-cycle strobe; period 0 disables the counter.
`default_nettype none
`include "pwmet_consts.vh"

module pwmet_prescaler (
	// Clock and reset
	input  wire       ref_clk,
	input  wire       sys_rst,
	// Control
	input  wire       enable,
	input  wire [1:0] period,
	input  wire       ev_in,
	// Status
	output reg  [1:0] count_r,
	output reg        pulse_r
);

	reg [1:0] count_nxt;
	wire      hit;

	// Count at or past period-1 on this event; a shrunk period fires at once
	assign hit = ev_in && (period != `PWMET_PRD_OFF)
		&& (count_r >= (period - `PWMET_CNT_ONE));

	// Next count
	always @* begin
		count_nxt = count_r;
		if (period == `PWMET_PRD_OFF)
			count_nxt = `PWMET_CNT_CLEAR;
		else if (hit && enable)
			count_nxt = `PWMET_CNT_CLEAR;
		else if (ev_in && !hit)
			count_nxt = count_r + `PWMET_CNT_ONE;
	end

	// Count and pulse registers; pulse ignores any earlier flag
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			count_r <= `PWMET_CNT_CLEAR;
			pulse_r <= 1'b0;
		end else begin
			count_r <= count_nxt;
			pulse_r <= hit && enable;
		end
	end

endmodule
`default_nettype wire

// *** dv/pwmet_asserts.sv ***
// Checker on the ports of the event-trigger block.
// Assumes one ref_clk domain and a synchronous active-high sys_rst.
`default_nettype none
module pwmet_asserts (
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        sys_rst,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [31:0] prdata,
	// Event causes and outputs
	input wire logic [15:0] timebase_count,
	input wire logic        dcmp_a_event1_conv,
	input wire logic        dcmp_b_event1_conv,
	input wire logic        conv_a_pulse,
	input wire logic        conv_b_pulse,
	input wire logic        module_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	// ----------------------------------------
	// Sequences
	// ----------------------------------------
	sequence s_acc;
		psel && penable;
	endsequence
	sequence s_map;
		s_acc ##0 (paddr == 12'h000 || paddr == 12'h004);
	endsequence
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	property p_ready; s_acc |-> pready; endproperty
	property p_err_ok; s_map |-> !pslverr; endproperty
	property p_err_bad; s_acc ##0 (paddr > 12'h004 || paddr[1:0] != 2'h0) |-> pslverr; endproperty
	property p_rsvd; s_acc ##0 (!pwrite && paddr == 12'h000) |-> prdata[7:4] == 4'h0 && prdata[31:16] == 16'h0;
	endproperty
	property p_rst; $fell(sys_rst) |-> !conv_a_pulse && !conv_b_pulse && !module_irq && prdata == 32'h0; endproperty
	property p_a_cause;
		conv_a_pulse |-> $past(dcmp_a_event1_conv) || $past(timebase_count) != $past(timebase_count, 2);
	endproperty
	property p_b_cause;
		conv_b_pulse |-> $past(dcmp_b_event1_conv) || $past(timebase_count) != $past(timebase_count, 2);
	endproperty
	property p_irq_cause; module_irq |-> $past(timebase_count) != $past(timebase_count, 2); endproperty
	a_ready: assert property (p_ready) else $error("pready low in access");
	a_err_ok: assert property (p_err_ok) else $error("pslverr on mapped register");
	a_err_bad: assert property (p_err_bad) else $error("no pslverr on unmapped address");
	a_rsvd: assert property (p_rsvd) else $error("reserved select bits not zero");
	a_rst: assert property (p_rst) else $error("output active after reset");
	a_a_cause: assert property (p_a_cause) else $error("conv a pulse without event");
	a_b_cause: assert property (p_b_cause) else $error("conv b pulse without event");
	a_irq_cause: assert property (p_irq_cause) else $error("irq without event");
endmodule
bind pwmet_event_trigger pwmet_asserts u_chk (
	.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pready(pready), .pslverr(pslverr), .prdata(prdata), .timebase_count(timebase_count),
	.dcmp_a_event1_conv(dcmp_a_event1_conv), .dcmp_b_event1_conv(dcmp_b_event1_conv),
	.conv_a_pulse(conv_a_pulse), .conv_b_pulse(conv_b_pulse), .module_irq(module_irq));
`default_nettype wire

// *** dv/pwmet_sink.sv ***
// Far-side model: converter sequencer and interrupt controller.
// Assumes one-cycle active-high pulses; it counts each one taken.
`default_nettype none
module pwmet_sink (
	// Clock and reset
	input wire logic       ref_clk,
	input wire logic       sys_rst,
	// Pulses taken
	input wire logic       conv_a_pulse,
	input wire logic       conv_b_pulse,
	input wire logic       module_irq,
	// Counts
	output var logic [7:0] cnt_a,
	output var logic [7:0] cnt_b,
	output var logic [7:0] cnt_i
);
	timeunit 1ns;
	timeprecision 1ps;
	// Count every pulse high at a clock edge
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			cnt_a <= 8'h00;
			cnt_b <= 8'h00;
			cnt_i <= 8'h00;
		end else begin
			cnt_a <= cnt_a + {7'h00, conv_a_pulse};
			cnt_b <= cnt_b + {7'h00, conv_b_pulse};
			cnt_i <= cnt_i + {7'h00, module_irq};
		end
	end
endmodule
`default_nettype wire

// *** dv/tb.sv ***
// Testbench: APB register access and time-base sweeps.
// Assumes pwmet_event_trigger, the sink model and the bound checker.
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic        pready, pslverr, timebase_count_up = 1'b1, conv_a_pulse, conv_b_pulse, module_irq;
	logic [15:0] timebase_count = 16'h0005, timebase_period = 16'h0064;
	logic [15:0] compare_value_a = 16'h0028, compare_value_b = 16'h003c;
	logic        dcmp_a_event1_conv = 1'b0, dcmp_b_event1_conv = 1'b0;
	logic [7:0]  cnt_a, cnt_b, cnt_i, sa, sb, si;
	logic [31:0] rd;
	logic        err;
	int          fails = 0, comparisons = 0;
	// Clock
	always #4 ref_clk = ~ref_clk;
	pwmet_event_trigger uut (.ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
		.pslverr, .prdata, .timebase_count, .timebase_period, .timebase_count_up, .compare_value_a,
		.compare_value_b, .dcmp_a_event1_conv, .dcmp_b_event1_conv, .conv_a_pulse, .conv_b_pulse, .module_irq);
	pwmet_sink u_sink (.ref_clk, .sys_rst, .conv_a_pulse, .conv_b_pulse, .module_irq, .cnt_a, .cnt_b, .cnt_i);
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			fails++;
			test_done();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic eerr);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
		chk({31'h0, err}, {31'h0, eerr});
	endtask
	task automatic visit(input logic [15:0] v, input logic up);
		@(posedge ref_clk);
		timebase_count <= v;
		timebase_count_up <= up;
		@(posedge ref_clk);
		timebase_count <= 16'h0005;
	endtask
	// Event k occurs k+1 times: zero, period, compare_value_a up/down, compare_value_b up/down
	task automatic sweep();
		logic [15:0] vals [6];
		vals = '{16'h0000, 16'h0064, 16'h0028, 16'h0028, 16'h003c, 16'h003c};
		for (int e = 0; e < 6; e++)
			for (int n = 0; n <= e; n++)
				visit(vals[e], (e % 2 == 0) || e == 1);
	endtask
	task automatic counts(input logic [7:0] ea, input logic [7:0] eb, input logic [7:0] ei);
		repeat (3) @(posedge ref_clk);
		chk({24'h0, cnt_a - sa}, {24'h0, ea});
		chk({24'h0, cnt_b - sb}, {24'h0, eb});
		chk({24'h0, cnt_i - si}, {24'h0, ei});
		{sa, sb, si} = {cnt_a, cnt_b, cnt_i};
	endtask
	task automatic test_done();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		{sa, sb, si} = 24'h0;
		rd_chk(12'h000, 32'h0, 1'b0);
		rd_chk(12'h004, 32'h0, 1'b0);
		apb(1'b1, 12'h000, 32'hffff);
		rd_chk(12'h000, 32'hff0f, 1'b0);
		apb(1'b1, 12'h004, 32'hffff);
		rd_chk(12'h004, 32'h3303, 1'b0);
		rd_chk(12'h008, 32'h0, 1'b1);
		apb(1'b1, 12'h004, 32'h1101);
		counts(8'd0, 8'd0, 8'd0);
		for (int c = 1; c < 8; c++) begin
			apb(1'b1, 12'h000, 32'h8808 | (c << 12) | (c << 8) | c);
			sweep();
			counts(8'(c - (c > 3)), 8'(c - (c > 3)), 8'(c - (c > 3)));
		end
		apb(1'b1, 12'h000, 32'h3303);
		sweep();
		counts(8'd0, 8'd0, 8'd0);
		apb(1'b1, 12'h000, 32'h8801);
		for (int k = 0; k < 3; k++) begin
			@(posedge ref_clk);
			dcmp_a_event1_conv <= (k < 2);
			dcmp_b_event1_conv <= 1'b1;
			@(posedge ref_clk);
			{dcmp_a_event1_conv, dcmp_b_event1_conv} <= 2'b00;
		end
		counts(8'd2, 8'd3, 8'd0);
		apb(1'b1, 12'h004, 32'h3201);
		apb(1'b1, 12'h000, 32'h9909);
		repeat (7) visit(16'h0000, 1'b1);
		counts(8'd3, 8'd2, 8'd7);
		rd_chk(12'h004, 32'h7601, 1'b0);
		apb(1'b1, 12'h004, 32'h0101);
		repeat (2) visit(16'h0000, 1'b1);
		counts(8'd2, 8'd0, 8'd2);
		@(posedge ref_clk);
		timebase_count <= 16'h0000;
		repeat (4) @(posedge ref_clk);
		timebase_count <= 16'h0005;
		counts(8'd1, 8'd0, 8'd1);
		@(posedge ref_clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rd_chk(12'h000, 32'h0, 1'b0);
		rd_chk(12'h004, 32'h0, 1'b0);
		test_done();
	end
	// Watchdog
	initial begin
		#50us;
		fails++;
		test_done();
	end
endmodule
`default_nettype wire
